//--- src/timer_xfer_cfg.svh
// Constants for the timer transfer instruction block.
// Notes on behaviour
// - Control five read copies into A.
// - Control five write loads from A.
// - Control six read copies into A.
// - Control six write loads from A.
// - Prescaler read: high to B, low to A.
// - Prescaler write loads counter and reload from B:A.
// - First timer read: high to B, low to A.
// - First timer write loads counter and reload.
// - Second timer read: high to B, low to A.
// - Second timer write loads counter and reload.
// - Third timer read: high to B, low to A.
// - Third timer write loads counter and reload.
// - Fourth timer read: high to B, low to A.
// - Fourth timer write loads counter and low reload.
// - High reload write leaves fourth counter alone.
// - First reload-only write keeps counter unchanged.
// - Third reload-only write keeps counter unchanged.
// - Fourth counter takes its low reload value.
// - Aux write loads A into counter and reload.
`ifndef TIMER_XFER_CFG_SVH
`define TIMER_XFER_CFG_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define TX_NIB_W 4
`define TX_PAIR_W 8
`define TX_OP_W 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TX_CTRL_RST 4'h0
`define TX_PAIR_RST 8'h00
`define TX_AUX_RST 4'h0

// ----------------------------------------
// Storage cells, addressed by index
// ----------------------------------------
`define TX_CNT_N 5
`define TX_RLD_N 6
`define TX_IDX_PS 0
`define TX_IDX_T1 1
`define TX_IDX_T2 2
`define TX_IDX_T3 3
`define TX_IDX_T4 4
`define TX_IDX_R4H 5

`endif

//--- src/timer_xfer_pkg.sv
// Types shared by the timer transfer instruction block.
`include "timer_xfer_cfg.svh"

package timer_xfer_pkg;

  // ----------------------------------------
  // Decoded instruction selector
  // ----------------------------------------
  typedef enum logic [`TX_OP_W-1:0] {
    OP_NONE = 5'b00000,
    OP_READ_TIMER_CTRL_FIVE = 5'b00001,
    OP_WRITE_TIMER_CTRL_FIVE = 5'b00010,
    OP_READ_TIMER_CTRL_SIX = 5'b00011,
    OP_WRITE_TIMER_CTRL_SIX = 5'b00100,
    OP_READ_PRESCALER_PAIR = 5'b00101,
    OP_WRITE_PRESCALER_PAIR = 5'b00110,
    OP_READ_FIRST_TIMER_PAIR = 5'b00111,
    OP_WRITE_FIRST_TIMER_PAIR = 5'b01000,
    OP_READ_SECOND_TIMER_PAIR = 5'b01001,
    OP_WRITE_SECOND_TIMER_PAIR = 5'b01010,
    OP_READ_THIRD_TIMER_PAIR = 5'b01011,
    OP_WRITE_THIRD_TIMER_PAIR = 5'b01100,
    OP_READ_FOURTH_TIMER_PAIR = 5'b01101,
    OP_WRITE_FOURTH_TIMER_PAIR = 5'b01110,
    OP_WRITE_FOURTH_HIGH_RELOAD = 5'b01111,
    OP_WRITE_FIRST_RELOAD_ONLY = 5'b10000,
    OP_WRITE_THIRD_RELOAD_ONLY = 5'b10001,
    OP_COPY_FOURTH_LOW_RELOAD = 5'b10010,
    OP_WRITE_AUX_TIMER = 5'b10011
  } tx_op_t;

endpackage

//--- src/nibble_pair_reg.sv
// Eight-bit cell loaded as a high and a low nibble in one edge.
`timescale 1ns/1ps
`default_nettype none
`include "timer_xfer_cfg.svh"

module nibble_pair_reg (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Load strobe and nibbles.
  input wire logic i_load,
  input wire logic [`TX_NIB_W-1:0] i_hi,
  input wire logic [`TX_NIB_W-1:0] i_lo,
  // Stored value.
  output logic [`TX_PAIR_W-1:0] o_value
);

  logic [`TX_PAIR_W-1:0] value_r;

  // Both nibbles land on the same edge, so no half-written value is seen.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      value_r <= `TX_PAIR_RST;
    end else if (i_load) begin
      value_r <= {i_hi, i_lo};
    end
  end

  assign o_value = value_r;

endmodule
`default_nettype wire

//--- src/timer_xfer_top.sv
// Execution of timer transfer instructions between A, B and timer registers.
`timescale 1ns/1ps
`default_nettype none
`include "timer_xfer_cfg.svh"

module timer_xfer_top (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Instruction from the decoder, one cycle per instruction.
  input wire logic i_exec,
  input wire timer_xfer_pkg::tx_op_t i_op,
  // Current accumulator and B register.
  input wire logic [`TX_NIB_W-1:0] i_reg_a,
  input wire logic [`TX_NIB_W-1:0] i_reg_b,
  // Write-back to A and B, one cycle after the instruction.
  output logic o_a_load,
  output logic [`TX_NIB_W-1:0] o_a_data,
  output logic o_b_load,
  output logic [`TX_NIB_W-1:0] o_b_data,
  // Completion and side effects.
  output logic o_done,
  output logic o_skip,
  output logic o_carry_we,
  // Control registers.
  output logic [`TX_NIB_W-1:0] o_timer_ctrl_five,
  output logic [`TX_NIB_W-1:0] o_timer_ctrl_six,
  // Counters.
  output logic [`TX_PAIR_W-1:0] o_prescaler,
  output logic [`TX_PAIR_W-1:0] o_first_timer,
  output logic [`TX_PAIR_W-1:0] o_second_timer,
  output logic [`TX_PAIR_W-1:0] o_third_timer,
  output logic [`TX_PAIR_W-1:0] o_fourth_timer,
  output logic [`TX_NIB_W-1:0] o_aux_timer,
  // Reload registers.
  output logic [`TX_PAIR_W-1:0] o_prescaler_reload,
  output logic [`TX_PAIR_W-1:0] o_first_timer_reload,
  output logic [`TX_PAIR_W-1:0] o_second_timer_reload,
  output logic [`TX_PAIR_W-1:0] o_third_timer_reload,
  output logic [`TX_PAIR_W-1:0] o_fourth_timer_low_reload,
  output logic [`TX_PAIR_W-1:0] o_fourth_timer_high_reload,
  output logic [`TX_NIB_W-1:0] o_aux_timer_reload
);

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------

  // True when the instruction loads counter cell idx.
  function automatic logic cnt_we(input timer_xfer_pkg::tx_op_t op, input int idx);
    case (op)
      timer_xfer_pkg::OP_WRITE_PRESCALER_PAIR: cnt_we = (idx == `TX_IDX_PS);
      timer_xfer_pkg::OP_WRITE_FIRST_TIMER_PAIR: cnt_we = (idx == `TX_IDX_T1);
      timer_xfer_pkg::OP_WRITE_SECOND_TIMER_PAIR: cnt_we = (idx == `TX_IDX_T2);
      timer_xfer_pkg::OP_WRITE_THIRD_TIMER_PAIR: cnt_we = (idx == `TX_IDX_T3);
      timer_xfer_pkg::OP_WRITE_FOURTH_TIMER_PAIR: cnt_we = (idx == `TX_IDX_T4);
      timer_xfer_pkg::OP_COPY_FOURTH_LOW_RELOAD: cnt_we = (idx == `TX_IDX_T4);
      default: cnt_we = 1'b0;
    endcase
  endfunction

  // True when the instruction loads reload cell idx.
  function automatic logic rld_we(input timer_xfer_pkg::tx_op_t op, input int idx);
    case (op)
      timer_xfer_pkg::OP_WRITE_PRESCALER_PAIR: rld_we = (idx == `TX_IDX_PS);
      timer_xfer_pkg::OP_WRITE_FIRST_TIMER_PAIR: rld_we = (idx == `TX_IDX_T1);
      timer_xfer_pkg::OP_WRITE_FIRST_RELOAD_ONLY: rld_we = (idx == `TX_IDX_T1);
      timer_xfer_pkg::OP_WRITE_SECOND_TIMER_PAIR: rld_we = (idx == `TX_IDX_T2);
      timer_xfer_pkg::OP_WRITE_THIRD_TIMER_PAIR: rld_we = (idx == `TX_IDX_T3);
      timer_xfer_pkg::OP_WRITE_THIRD_RELOAD_ONLY: rld_we = (idx == `TX_IDX_T3);
      timer_xfer_pkg::OP_WRITE_FOURTH_TIMER_PAIR: rld_we = (idx == `TX_IDX_T4);
      timer_xfer_pkg::OP_WRITE_FOURTH_HIGH_RELOAD: rld_we = (idx == `TX_IDX_R4H);
      default: rld_we = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Storage
  // ----------------------------------------

  timer_xfer_pkg::tx_op_t op_eff;
  logic [`TX_PAIR_W-1:0] cnt [`TX_CNT_N];
  logic [`TX_PAIR_W-1:0] rld [`TX_RLD_N];
  logic [`TX_NIB_W-1:0] ctrl_five_r;
  logic [`TX_NIB_W-1:0] ctrl_six_r;
  logic [`TX_NIB_W-1:0] aux_r;
  logic [`TX_NIB_W-1:0] aux_reload_r;

  // An instruction only counts in the cycle that the decoder marks it.
  assign op_eff = i_exec ? i_op : timer_xfer_pkg::OP_NONE;

  // Counter cells; the fourth counter may instead take its low reload value.
  for (genvar gi = 0; gi < `TX_CNT_N; gi++) begin : g_cnt
    logic copy_low;
    assign copy_low = (op_eff == timer_xfer_pkg::OP_COPY_FOURTH_LOW_RELOAD);
    nibble_pair_reg u_cell (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_load(cnt_we(op_eff, gi)),
      .i_hi(copy_low ? rld[`TX_IDX_T4][7:4] : i_reg_b),
      .i_lo(copy_low ? rld[`TX_IDX_T4][3:0] : i_reg_a),
      .o_value(cnt[gi])
    );
  end

  // Reload cells share the B:A data path with the counters.
  for (genvar gj = 0; gj < `TX_RLD_N; gj++) begin : g_rld
    nibble_pair_reg u_cell (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_load(rld_we(op_eff, gj)),
      .i_hi(i_reg_b),
      .i_lo(i_reg_a),
      .o_value(rld[gj])
    );
  end

  // ----------------------------------------
  // Nibble registers
  // ----------------------------------------

  // Control registers five and six take A on their write instruction.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_five_r <= `TX_CTRL_RST;
      ctrl_six_r <= `TX_CTRL_RST;
    end else begin
      if (op_eff == timer_xfer_pkg::OP_WRITE_TIMER_CTRL_FIVE) begin
        ctrl_five_r <= i_reg_a;
      end
      if (op_eff == timer_xfer_pkg::OP_WRITE_TIMER_CTRL_SIX) begin
        ctrl_six_r <= i_reg_a;
      end
    end
  end

  // The auxiliary timer and its reload are written together from A.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aux_r <= `TX_AUX_RST;
      aux_reload_r <= `TX_AUX_RST;
    end else if (op_eff == timer_xfer_pkg::OP_WRITE_AUX_TIMER) begin
      aux_r <= i_reg_a;
      aux_reload_r <= i_reg_a;
    end
  end

  // ----------------------------------------
  // Read-back to A and B
  // ----------------------------------------

  // Reads sample the value before any write of the same edge; with one
  // instruction per cycle a read never races its own write.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_a_load <= 1'b0;
      o_b_load <= 1'b0;
      o_a_data <= `TX_AUX_RST;
      o_b_data <= `TX_AUX_RST;
    end else begin
      o_a_load <= 1'b0;
      o_b_load <= 1'b0;
      case (op_eff)
        timer_xfer_pkg::OP_READ_TIMER_CTRL_FIVE: begin
          o_a_load <= 1'b1;
          o_a_data <= ctrl_five_r;
        end
        timer_xfer_pkg::OP_READ_TIMER_CTRL_SIX: begin
          o_a_load <= 1'b1;
          o_a_data <= ctrl_six_r;
        end
        timer_xfer_pkg::OP_READ_PRESCALER_PAIR: begin
          {o_b_load, o_a_load} <= 2'h3;
          {o_b_data, o_a_data} <= cnt[`TX_IDX_PS];
        end
        timer_xfer_pkg::OP_READ_FIRST_TIMER_PAIR: begin
          {o_b_load, o_a_load} <= 2'h3;
          {o_b_data, o_a_data} <= cnt[`TX_IDX_T1];
        end
        timer_xfer_pkg::OP_READ_SECOND_TIMER_PAIR: begin
          {o_b_load, o_a_load} <= 2'h3;
          {o_b_data, o_a_data} <= cnt[`TX_IDX_T2];
        end
        timer_xfer_pkg::OP_READ_THIRD_TIMER_PAIR: begin
          {o_b_load, o_a_load} <= 2'h3;
          {o_b_data, o_a_data} <= cnt[`TX_IDX_T3];
        end
        timer_xfer_pkg::OP_READ_FOURTH_TIMER_PAIR: begin
          {o_b_load, o_a_load} <= 2'h3;
          {o_b_data, o_a_data} <= cnt[`TX_IDX_T4];
        end
        default: begin
        end
      endcase
    end
  end

  // Every instruction here finishes in one cycle and never skips or
  // touches carry; the flags stay low so the core sequencer can OR them in.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_done <= 1'b0;
      o_skip <= 1'b0;
      o_carry_we <= 1'b0;
    end else begin
      o_done <= (op_eff != timer_xfer_pkg::OP_NONE);
      o_skip <= 1'b0;
      o_carry_we <= 1'b0;
    end
  end

  // ----------------------------------------
  // Register outputs
  // ----------------------------------------

  assign o_timer_ctrl_five = ctrl_five_r;
  assign o_timer_ctrl_six = ctrl_six_r;
  assign o_prescaler = cnt[`TX_IDX_PS];
  assign o_first_timer = cnt[`TX_IDX_T1];
  assign o_second_timer = cnt[`TX_IDX_T2];
  assign o_third_timer = cnt[`TX_IDX_T3];
  assign o_fourth_timer = cnt[`TX_IDX_T4];
  assign o_aux_timer = aux_r;
  assign o_prescaler_reload = rld[`TX_IDX_PS];
  assign o_first_timer_reload = rld[`TX_IDX_T1];
  assign o_second_timer_reload = rld[`TX_IDX_T2];
  assign o_third_timer_reload = rld[`TX_IDX_T3];
  assign o_fourth_timer_low_reload = rld[`TX_IDX_T4];
  assign o_fourth_timer_high_reload = rld[`TX_IDX_R4H];
  assign o_aux_timer_reload = aux_reload_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_ctrl5_read: assert property (
    op_eff == timer_xfer_pkg::OP_READ_TIMER_CTRL_FIVE
    |=> o_a_load && !o_b_load && o_a_data == $past(ctrl_five_r))
    else $error("Control five read wrong.");
  a_ctrl5_write: assert property (
    op_eff == timer_xfer_pkg::OP_WRITE_TIMER_CTRL_FIVE
    |=> o_timer_ctrl_five == $past(i_reg_a) && !o_a_load)
    else $error("Control five write wrong.");
  a_ctrl6_read: assert property (
    op_eff == timer_xfer_pkg::OP_READ_TIMER_CTRL_SIX
    |=> o_a_load && o_a_data == $past(ctrl_six_r))
    else $error("Control six read wrong.");
  a_ctrl6_write: assert property (
    op_eff == timer_xfer_pkg::OP_WRITE_TIMER_CTRL_SIX
    |=> o_timer_ctrl_six == $past(i_reg_a) && $stable(o_timer_ctrl_five))
    else $error("Control six write wrong.");
  a_ps_read: assert property (
    op_eff == timer_xfer_pkg::OP_READ_PRESCALER_PAIR
    |=> o_a_load && o_b_load && {o_b_data, o_a_data} == $past(o_prescaler))
    else $error("Prescaler read wrong.");
  a_ps_write: assert property (
    op_eff == timer_xfer_pkg::OP_WRITE_PRESCALER_PAIR
    |=> o_prescaler == {$past(i_reg_b), $past(i_reg_a)}
        && o_prescaler_reload == o_prescaler)
    else $error("Prescaler write wrong.");
  a_t1_read: assert property (
    op_eff == timer_xfer_pkg::OP_READ_FIRST_TIMER_PAIR
    |=> {o_b_data, o_a_data} == $past(o_first_timer) && o_b_load)
    else $error("First timer read wrong.");
  a_t1_write: assert property (
    op_eff == timer_xfer_pkg::OP_WRITE_FIRST_TIMER_PAIR
    |=> o_first_timer == {$past(i_reg_b), $past(i_reg_a)})
    else $error("First timer write wrong.");
  a_t2_read: assert property (
    op_eff == timer_xfer_pkg::OP_READ_SECOND_TIMER_PAIR
    |=> {o_b_data, o_a_data} == $past(o_second_timer) && o_a_load)
    else $error("Second timer read wrong.");
  a_t2_write: assert property (
    op_eff == timer_xfer_pkg::OP_WRITE_SECOND_TIMER_PAIR
    |=> o_second_timer_reload == {$past(i_reg_b), $past(i_reg_a)})
    else $error("Second timer write wrong.");
  a_t3_read: assert property (
    op_eff == timer_xfer_pkg::OP_READ_THIRD_TIMER_PAIR
    |=> {o_b_data, o_a_data} == $past(o_third_timer))
    else $error("Third timer read wrong.");
  a_t3_write: assert property (
    op_eff == timer_xfer_pkg::OP_WRITE_THIRD_TIMER_PAIR
    |=> o_third_timer == {$past(i_reg_b), $past(i_reg_a)})
    else $error("Third timer write wrong.");
  a_t4_read: assert property (
    op_eff == timer_xfer_pkg::OP_READ_FOURTH_TIMER_PAIR
    |=> {o_b_data, o_a_data} == $past(o_fourth_timer))
    else $error("Fourth timer read wrong.");
  a_t4_write: assert property (
    op_eff == timer_xfer_pkg::OP_WRITE_FOURTH_TIMER_PAIR
    |=> o_fourth_timer_low_reload == {$past(i_reg_b), $past(i_reg_a)}
        && $stable(o_fourth_timer_high_reload))
    else $error("Fourth timer write wrong.");
  a_t4_high: assert property (
    op_eff == timer_xfer_pkg::OP_WRITE_FOURTH_HIGH_RELOAD
    |=> o_fourth_timer_high_reload == {$past(i_reg_b), $past(i_reg_a)}
        && $stable(o_fourth_timer))
    else $error("High reload write wrong.");
  a_r1_only: assert property (
    op_eff == timer_xfer_pkg::OP_WRITE_FIRST_RELOAD_ONLY
    |=> o_first_timer_reload == {$past(i_reg_b), $past(i_reg_a)}
        && $stable(o_first_timer))
    else $error("First reload-only write wrong.");
  a_r3_only: assert property (
    op_eff == timer_xfer_pkg::OP_WRITE_THIRD_RELOAD_ONLY
    |=> o_third_timer_reload == {$past(i_reg_b), $past(i_reg_a)}
        && $stable(o_third_timer))
    else $error("Third reload-only write wrong.");
  a_t4_copy: assert property (
    op_eff == timer_xfer_pkg::OP_COPY_FOURTH_LOW_RELOAD
    |=> o_fourth_timer == $past(o_fourth_timer_low_reload))
    else $error("Low reload copy wrong.");
  a_aux_write: assert property (
    op_eff == timer_xfer_pkg::OP_WRITE_AUX_TIMER
    |=> o_aux_timer == $past(i_reg_a) && o_aux_timer_reload == $past(i_reg_a))
    else $error("Aux timer write wrong.");
  a_one_cycle: assert property (
    i_exec && i_op != timer_xfer_pkg::OP_NONE
    |=> o_done && !o_skip && !o_carry_we)
    else $error("Instruction not single cycle.");
  a_pair_atomic: assert property (
    op_eff == timer_xfer_pkg::OP_WRITE_SECOND_TIMER_PAIR
    |=> o_second_timer == o_second_timer_reload
        && o_second_timer == {$past(i_reg_b), $past(i_reg_a)})
    else $error("Counter and reload split.");

endmodule
`default_nettype wire

//--- testbench/cpu_ab_model.sv
// CPU-side model of accumulator A and register B facing the transfer block.
`timescale 1ns/1ps
`default_nettype none
`include "timer_xfer_cfg.svh"

module cpu_ab_model (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Operand values placed by the running program this cycle.
  input wire logic i_set,
  input wire logic [`TX_NIB_W-1:0] i_set_a,
  input wire logic [`TX_NIB_W-1:0] i_set_b,
  // Write-back from the transfer block.
  input wire logic i_a_load,
  input wire logic [`TX_NIB_W-1:0] i_a_data,
  input wire logic i_b_load,
  input wire logic [`TX_NIB_W-1:0] i_b_data,
  // Operands towards the block and the stored registers.
  output logic [`TX_NIB_W-1:0] o_reg_a,
  output logic [`TX_NIB_W-1:0] o_reg_b,
  output logic [`TX_NIB_W-1:0] o_a_r,
  output logic [`TX_NIB_W-1:0] o_b_r
);
  // Accumulator takes the write-back pulse; a missed pulse leaves a stale value behind.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_a_r <= 4'h0;
    end else if (i_a_load) begin
      o_a_r <= i_a_data;
    end
  end

  // Register B is loaded only by the pair reads.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_b_r <= 4'h0;
    end else if (i_b_load) begin
      o_b_r <= i_b_data;
    end
  end

  // The program's own values win on the operand path, as an earlier instruction would.
  assign o_reg_a = i_set ? i_set_a : o_a_r;
  assign o_reg_b = i_set ? i_set_b : o_b_r;
endmodule
`default_nettype wire

//--- testbench/timer_xfer_top_test.sv
// Self-checking bench for the timer transfer instruction block.
`timescale 1ns/1ps
`default_nettype none
`include "timer_xfer_cfg.svh"

module timer_xfer_top_test;
  // ----------------------------------------
  // Signals and reference state
  // ----------------------------------------
  typedef struct packed {
    logic [9:0] rd;
    logic [103:0] rg;
  } note_t;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_exec = 1'b0;
  timer_xfer_pkg::tx_op_t i_op = timer_xfer_pkg::OP_NONE;
  logic set = 1'b0;
  logic [3:0] set_a = 4'h0;
  logic [3:0] set_b = 4'h0;
  wire logic [3:0] reg_a, reg_b, cpu_a, cpu_b, a_data, b_data, c5, c6, ax, rax;
  wire logic a_load, b_load, done, skip, carry_we;
  wire logic [7:0] ps, t1, t2, t3, t4, prescaler_reload, r1, r2, r3, r4l, r4h;
  int n_errors = 0;
  int checks_done = 0;
  note_t notes[$];
  logic [3:0] m5, m6, max, mrax, mad, mbd;
  logic [7:0] mc[5];
  logic [7:0] mr[6];
  logic pend = 1'b0;
  logic [7:0] pend_ab = 8'h00;

  always #2.5 i_clk = ~i_clk;

  timer_xfer_top timer_xfer_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_exec(i_exec), .i_op(i_op),
    .i_reg_a(reg_a), .i_reg_b(reg_b), .o_a_load(a_load), .o_a_data(a_data), .o_b_load(b_load),
    .o_b_data(b_data), .o_done(done), .o_skip(skip), .o_carry_we(carry_we),
    .o_timer_ctrl_five(c5), .o_timer_ctrl_six(c6), .o_prescaler(ps), .o_first_timer(t1),
    .o_second_timer(t2), .o_third_timer(t3), .o_fourth_timer(t4), .o_aux_timer(ax),
    .o_prescaler_reload(prescaler_reload), .o_first_timer_reload(r1), .o_second_timer_reload(r2),
    .o_third_timer_reload(r3), .o_fourth_timer_low_reload(r4l),
    .o_fourth_timer_high_reload(r4h), .o_aux_timer_reload(rax));

  cpu_ab_model cpu_ab_model_i (.i_clk(i_clk), .i_rst(i_rst), .i_set(set), .i_set_a(set_a),
    .i_set_b(set_b), .i_a_load(a_load), .i_a_data(a_data), .i_b_load(b_load),
    .i_b_data(b_data), .o_reg_a(reg_a), .o_reg_b(reg_b), .o_a_r(cpu_a), .o_b_r(cpu_b));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Reference copy returns to the chosen all-zero reset state.
  task automatic model_clear();
    {m5, m6, max, mrax, mad, mbd} = 24'h000000;
    for (int k = 0; k < 6; k++) begin
      mr[k] = 8'h00;
      if (k < 5) mc[k] = 8'h00;
    end
    notes.delete();
    pend = 1'b0;
  endtask

  function automatic logic [103:0] regs_exp();
    return {m5, m6, mc[0], mc[1], mc[2], mc[3], mc[4], max,
            mr[0], mr[1], mr[2], mr[3], mr[4], mr[5], mrax};
  endfunction

  function automatic logic [103:0] regs_seen();
    return {c5, c6, ps, t1, t2, t3, t4, ax, prescaler_reload, r1, r2, r3, r4l, r4h, rax};
  endfunction

  // Drives one instruction and notes its effect; pair ops use the package's odd/even codes.
  task automatic issue(input int k, input logic [3:0] a, input logic [3:0] b);
    int rc;
    int rp;
    int wp;
    rc = 0;
    rp = (k >= 5 && k <= 13 && k % 2 == 1) ? (k - 5) / 2 : -1;
    wp = (k >= 6 && k <= 14 && k % 2 == 0) ? (k - 6) / 2 : -1;
    case (timer_xfer_pkg::tx_op_t'(k))
      timer_xfer_pkg::OP_READ_TIMER_CTRL_FIVE: rc = 5;
      timer_xfer_pkg::OP_READ_TIMER_CTRL_SIX: rc = 6;
      timer_xfer_pkg::OP_WRITE_TIMER_CTRL_FIVE: m5 = a;
      timer_xfer_pkg::OP_WRITE_TIMER_CTRL_SIX: m6 = a;
      timer_xfer_pkg::OP_WRITE_FOURTH_HIGH_RELOAD: mr[5] = {b, a};
      timer_xfer_pkg::OP_WRITE_FIRST_RELOAD_ONLY: mr[1] = {b, a};
      timer_xfer_pkg::OP_WRITE_THIRD_RELOAD_ONLY: mr[3] = {b, a};
      timer_xfer_pkg::OP_COPY_FOURTH_LOW_RELOAD: mc[4] = mr[4];
      timer_xfer_pkg::OP_WRITE_AUX_TIMER: begin
        max = a;
        mrax = a;
      end
      default: ;
    endcase
    if (rc != 0) mad = (rc == 5) ? m5 : m6;
    if (rp >= 0) {mbd, mad} = mc[rp];
    if (wp >= 0) mc[wp] = {b, a};
    if (wp >= 0) mr[wp] = {b, a};
    @(negedge i_clk);
    i_exec <= 1'b1;
    i_op <= timer_xfer_pkg::tx_op_t'(k);
    set <= 1'b1;
    set_a <= a;
    set_b <= b;
    // Queued only once the instruction is on the pins, so no note runs ahead of its edge.
    if (k != 0) notes.push_back({rc != 0 || rp >= 0, mad, rp >= 0, mbd, regs_exp()});
  endtask

  // An idle cycle still shows a random selector, which must be ignored.
  task automatic idle();
    @(negedge i_clk);
    i_exec <= 1'b0;
    i_op <= timer_xfer_pkg::tx_op_t'($urandom_range(19, 0));
    set <= 1'b0;
  endtask

  task automatic random_ops(input int n);
    for (int j = 0; j < n; j++) begin
      if ($urandom_range(3, 0) == 0) idle();
      else issue($urandom_range(19, 0), 4'($urandom), 4'($urandom));
    end
    idle();
  endtask

  // ----------------------------------------
  // Monitor: each completion consumes the oldest note
  // ----------------------------------------
  always @(posedge i_clk) begin
    note_t n;
    #1;
    if (!i_rst) begin
      if (pend) check({cpu_b, cpu_a}, pend_ab);
      pend = 1'b0;
      check({skip, carry_we}, 2'b00);
      if (done !== 1'b1) begin
        check({done, a_load, b_load}, 3'b000);
      end else if (notes.size() == 0) begin
        check(1'b1, 1'b0);
      end else begin
        n = notes.pop_front();
        check({a_load, a_data, b_load, b_data}, n.rd);
        check(regs_seen(), n.rg);
        check(regs_seen(), n.rg);
        pend = n.rd[9] | n.rd[4];
        pend_ab = {n.rd[3:0], n.rd[8:5]};
      end
      check(notes.size(), 0);
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(7691));
    model_clear();
    repeat (6) @(posedge i_clk);
    @(negedge i_clk);
    i_rst <= 1'b0;
    #1;
    check({a_load, b_load, done, a_data, b_data, regs_seen()}, 115'h0);
    // Every instruction back to back, then each of the seven writes that has a read followed at once by its read.
    for (int k = 0; k < 20; k++) issue(k, 4'($urandom), 4'($urandom));
    for (int j = 1; j < 8; j++) begin
      issue(2 * j, 4'($urandom), 4'($urandom));
      issue(2 * j - 1, 4'($urandom), 4'($urandom));
    end
    random_ops(400);
    // A reset in mid-stream must clear everything without a clock edge.
    @(negedge i_clk);
    i_rst <= 1'b1;
    i_exec <= 1'b0;
    model_clear();
    #1;
    check({a_load, b_load, done, a_data, b_data, regs_seen(), cpu_a, cpu_b}, 123'h0);
    @(negedge i_clk);
    i_rst <= 1'b0;
    random_ops(200);
    repeat (3) @(negedge i_clk);
    summarize();
  end
endmodule
`default_nettype wire
